// ---- common/wdtac_pkg.sv ----
// Constants shared by the watchdog with timed-access protection
//
// How it works
// - Extended enable bit four gates watchdog interrupt
// - Extended priority bit four selects high
// - Interval field bits 7:6 of 0x8e
// - Intervals are 2^17, 2^20, 2^23, 2^26 clocks
// - Counter advances every clock, no prescaler
// - Expiry sets interrupt flag, polled if disabled
// - Flag and enable request interrupt regardless reset
// - Reset follows expiry by 512 unless restarted
// - Reset delay independent of interrupt enable
// - Reset enable bit gates only reset generation
// - Writing restart bit clears the count
// - Watchdog reset sets cause flag, software clears
// - Disabled reset never touches cause flag
// - Watchdog reset keeps counter running from zero
// - Hardware clears the restart bit itself
// - Software-set interrupt flag also raises interrupt
// - Global enable must also be set
package wdtac_pkg;

    // ----------------------------------------------------------------
    // Register addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CKCTL = 8'h8e;
    localparam logic [7:0] ADDR_TAKEY = 8'hc7;
    localparam logic [7:0] ADDR_WDCTL = 8'hd8;
    localparam logic [7:0] ADDR_XIEN  = 8'he8;
    localparam logic [7:0] ADDR_XIPR  = 8'hf8;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int         BIT_WDOG_IRQ   = 4;
    localparam int         BIT_EXP_FLAG   = 3;
    localparam int         BIT_CAUSE      = 2;
    localparam int         BIT_RST_EN     = 1;
    localparam int         BIT_RESTART    = 0;
    localparam int         POS_INTERVAL   = 6;
    localparam logic [7:0] CKCTL_RESET    = 8'h03;
    localparam logic [7:0] WDCTL_RESET    = 8'h00;

    // ----------------------------------------------------------------
    // Timed-access keys
    // ----------------------------------------------------------------
    localparam logic [7:0] UNLOCK_KEY_A   = 8'haa;
    localparam logic [7:0] UNLOCK_KEY_B   = 8'h55;

    // ----------------------------------------------------------------
    // Cycle counts
    // ----------------------------------------------------------------
    localparam int         COUNT_W        = 26;
    localparam int         INTERVAL_SEL0  = 131072;
    localparam int         INTERVAL_SEL1  = 1048576;
    localparam int         INTERVAL_SEL2  = 8388608;
    localparam int         INTERVAL_SEL3  = 67108864;
    localparam logic [9:0] RESET_DELAY    = 10'd512;

    typedef enum logic [2:0] {
        WDTAC_LOCK_IDLE = 3'b001,
        WDTAC_LOCK_KEY1 = 3'b010,
        WDTAC_LOCK_OPEN = 3'b100
    } wdtac_lock_state_t;

endpackage

// ---- common/wdtac_sfr_if.sv ----
// Register access signals shared between watchdog and unlock gate
`timescale 1ns/1ps
interface wdtac_sfr_if;
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       unlock;

    modport core
    (
        output wr,
        output rd,
        output addr,
        output wdata,
        input  unlock
    );

    modport gate
    (
        input  wr,
        input  rd,
        input  addr,
        input  wdata,
        output unlock
    );
endinterface

// ---- verilog/wdtac_unlock.sv ----
// Timed-access unlock sequencer for the watchdog control register
`timescale 1ns/1ps
module wdtac_unlock
(
    input wire logic clk,
    input wire logic rst,
    wdtac_sfr_if.gate bus
);
    import wdtac_pkg::*;

    wdtac_lock_state_t state;
    wdtac_lock_state_t next_state;
    logic              key1_hit;
    logic              key2_hit;
    logic              access;

    assign access   = bus.wr || bus.rd;
    assign key1_hit = bus.wr && (bus.addr == ADDR_TAKEY)
                      && (bus.wdata == UNLOCK_KEY_A);
    assign key2_hit = bus.wr && (bus.addr == ADDR_TAKEY)
                      && (bus.wdata == UNLOCK_KEY_B);

    always_comb
    begin
        next_state = state;
        if (access)
        begin
            case (state)
                WDTAC_LOCK_KEY1:
                    next_state = key2_hit ? WDTAC_LOCK_OPEN
                               : (key1_hit ? WDTAC_LOCK_KEY1
                                           : WDTAC_LOCK_IDLE);
                default:
                    // Any access consumes an open window
                    next_state = key1_hit ? WDTAC_LOCK_KEY1
                                          : WDTAC_LOCK_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            state <= WDTAC_LOCK_IDLE;
        else
            state <= next_state;
    end

    assign bus.unlock = (state == WDTAC_LOCK_OPEN);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_key_pair;
        key1_hit ##1 key2_hit;
    endsequence

    a_key_pair_opens: assert property (
        @(posedge clk) disable iff (rst)
        s_key_pair |=> bus.unlock)
        else $error("Key pair did not open the window");

    // Idle cycles between the keys are allowed
    sequence s_key_gap;
        key1_hit ##1 !access ##1 key2_hit;
    endsequence

    a_gap_pair_opens: assert property (
        @(posedge clk) disable iff (rst)
        s_key_gap |=> bus.unlock)
        else $error("Key pair with idle gap did not open");

    a_open_single_use: assert property (
        @(posedge clk) disable iff (rst)
        bus.unlock && access |=> !bus.unlock)
        else $error("Unlock survived an access");
endmodule

// ---- verilog/wdtac_watchdog.sv ----
// Watchdog timer with interval select, delayed reset and timed access
`timescale 1ns/1ps
module wdtac_watchdog
#(
    parameter int INTERVAL_0 = wdtac_pkg::INTERVAL_SEL0,
    parameter int INTERVAL_1 = wdtac_pkg::INTERVAL_SEL1,
    parameter int INTERVAL_2 = wdtac_pkg::INTERVAL_SEL2,
    parameter int INTERVAL_3 = wdtac_pkg::INTERVAL_SEL3
)
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       global_irq_enable,
    output logic      [7:0] sfr_rdata,
    output logic            wdog_irq_req,
    output logic            wdog_irq_high,
    output logic            wdog_core_reset,
    output logic      [2:0] stretch_field
);
    import wdtac_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [1:0]         interval_select;
    logic [2:0]         stretch;
    logic               wdog_irq_enable;
    logic               wdog_irq_priority;
    logic               reset_gen_enable;
    logic               reset_cause_flag;
    logic               expiry_irq_flag;
    logic               count_restart;
    logic [COUNT_W-1:0] count;
    logic               pending;
    logic [9:0]         delay;
    logic [7:0]         rdata;
    logic               irq_req;
    logic               core_reset;

    logic [1:0]         next_interval_select;
    logic [2:0]         next_stretch;
    logic               next_wdog_irq_enable;
    logic               next_wdog_irq_priority;
    logic               next_reset_gen_enable;
    logic               next_reset_cause_flag;
    logic               next_expiry_irq_flag;
    logic               next_count_restart;
    logic [COUNT_W-1:0] next_count;
    logic               next_pending;
    logic [9:0]         next_delay;
    logic [7:0]         next_rdata;
    logic               next_irq_req;
    logic               next_core_reset;

    logic [COUNT_W-1:0] last_count;
    logic               expire;
    logic               fire;
    logic               wr_wdctl;
    logic               restart_now;

    wdtac_sfr_if bus ();

    assign bus.wr    = sfr_wr;
    assign bus.rd    = sfr_rd;
    assign bus.addr  = sfr_addr;
    assign bus.wdata = sfr_wdata;

    wdtac_unlock wdtac_unlock_i
    (
        .clk (clk),
        .rst (rst),
        .bus (bus)
    );

    // ----------------------------------------------------------------
    // Interval and expiry
    // ----------------------------------------------------------------
    always_comb
    begin
        case (interval_select)
            2'b00:   last_count = COUNT_W'(INTERVAL_0 - 1);
            2'b01:   last_count = COUNT_W'(INTERVAL_1 - 1);
            2'b10:   last_count = COUNT_W'(INTERVAL_2 - 1);
            default: last_count = COUNT_W'(INTERVAL_3 - 1);
        endcase
    end

    // Locked writes to the control register are silently dropped
    assign wr_wdctl    = sfr_wr && (sfr_addr == ADDR_WDCTL)
                         && bus.unlock;
    assign restart_now = wr_wdctl && sfr_wdata[BIT_RESTART];
    assign expire      = (count == last_count);
    assign fire        = pending && reset_gen_enable && !restart_now
                         && (delay == RESET_DELAY - 10'd1);

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        next_interval_select   = interval_select;
        next_stretch           = stretch;
        next_wdog_irq_enable   = wdog_irq_enable;
        next_wdog_irq_priority = wdog_irq_priority;
        next_reset_gen_enable  = reset_gen_enable;
        next_reset_cause_flag  = reset_cause_flag;
        next_expiry_irq_flag   = expiry_irq_flag;
        next_rdata             = 8'h00;

        if (sfr_wr && (sfr_addr == ADDR_CKCTL))
        begin
            next_interval_select = sfr_wdata[POS_INTERVAL +: 2];
            next_stretch         = sfr_wdata[2:0];
        end
        else if (sfr_wr && (sfr_addr == ADDR_XIEN))
        begin
            next_wdog_irq_enable = sfr_wdata[BIT_WDOG_IRQ];
        end
        else if (sfr_wr && (sfr_addr == ADDR_XIPR))
        begin
            next_wdog_irq_priority = sfr_wdata[BIT_WDOG_IRQ];
        end
        else if (wr_wdctl)
        begin
            next_reset_gen_enable = sfr_wdata[BIT_RST_EN];
            next_reset_cause_flag = sfr_wdata[BIT_CAUSE];
            next_expiry_irq_flag  = sfr_wdata[BIT_EXP_FLAG];
        end

        // Hardware sets win over a software clear in the same cycle
        if (expire)
            next_expiry_irq_flag = 1'b1;
        if (fire)
            next_reset_cause_flag = 1'b1;

        if (sfr_rd)
        begin
            if (sfr_addr == ADDR_CKCTL)
                next_rdata = {interval_select, 3'b000, stretch};
            else if (sfr_addr == ADDR_WDCTL)
                next_rdata = {4'h0, expiry_irq_flag, reset_cause_flag,
                              reset_gen_enable, count_restart};
            else if (sfr_addr == ADDR_XIEN)
                next_rdata = 8'(wdog_irq_enable) << BIT_WDOG_IRQ;
            else if (sfr_addr == ADDR_XIPR)
                next_rdata = 8'(wdog_irq_priority) << BIT_WDOG_IRQ;
            else
                next_rdata = 8'h00;
        end
    end

    always_comb
    begin
        // Restart bit is a one-cycle strobe, never held
        next_count_restart = restart_now;
        if (restart_now || fire || expire)
            next_count = '0;
        else
            next_count = count + COUNT_W'(1);

        next_pending = pending;
        next_delay   = delay;
        if (restart_now || !reset_gen_enable || fire)
        begin
            next_pending = 1'b0;
            next_delay   = 10'd0;
        end
        else if (expire)
        begin
            // Armed whatever the interrupt enable says
            next_pending = 1'b1;
            next_delay   = 10'd0;
        end
        else if (pending)
        begin
            next_delay = delay + 10'd1;
        end

        next_core_reset = fire;
        next_irq_req    = expiry_irq_flag && wdog_irq_enable
                          && global_irq_enable;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            interval_select   <= CKCTL_RESET[POS_INTERVAL +: 2];
            stretch           <= CKCTL_RESET[2:0];
            wdog_irq_enable   <= 1'b0;
            wdog_irq_priority <= 1'b0;
            reset_gen_enable  <= WDCTL_RESET[BIT_RST_EN];
            reset_cause_flag  <= WDCTL_RESET[BIT_CAUSE];
            expiry_irq_flag   <= WDCTL_RESET[BIT_EXP_FLAG];
            count_restart     <= WDCTL_RESET[BIT_RESTART];
            count             <= '0;
            pending           <= 1'b0;
            delay             <= 10'd0;
            rdata             <= 8'h00;
            irq_req           <= 1'b0;
            core_reset        <= 1'b0;
        end
        else
        begin
            interval_select   <= next_interval_select;
            stretch           <= next_stretch;
            wdog_irq_enable   <= next_wdog_irq_enable;
            wdog_irq_priority <= next_wdog_irq_priority;
            reset_gen_enable  <= next_reset_gen_enable;
            reset_cause_flag  <= next_reset_cause_flag;
            expiry_irq_flag   <= next_expiry_irq_flag;
            count_restart     <= next_count_restart;
            count             <= next_count;
            pending           <= next_pending;
            delay             <= next_delay;
            rdata             <= next_rdata;
            irq_req           <= next_irq_req;
            core_reset        <= next_core_reset;
        end
    end

    assign sfr_rdata       = rdata;
    assign wdog_irq_req    = irq_req;
    assign wdog_irq_high   = wdog_irq_priority;
    assign wdog_core_reset = core_reset;
    assign stretch_field   = stretch;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [9:0] since_expiry;

    always_ff @(posedge clk)
    begin
        if (rst)
            since_expiry <= 10'h3ff;
        else if (expire)
            since_expiry <= 10'd0;
        else if (since_expiry != 10'h3ff)
            since_expiry <= since_expiry + 10'd1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_locked_write;
        sfr_wr && (sfr_addr == ADDR_WDCTL) && !bus.unlock && !fire;
    endsequence

    sequence s_restart_write;
        wr_wdctl && sfr_wdata[BIT_RESTART];
    endsequence

    a_locked_ignored: assert property (
        s_locked_write |=> $stable(reset_gen_enable)
                           && $stable(reset_cause_flag))
        else $error("Locked control write took effect");

    a_restart_clears: assert property (
        s_restart_write |=> (count == '0) && count_restart)
        else $error("Restart did not clear the count");

    a_restart_selfclr: assert property (
        s_restart_write ##1 !restart_now |=> !count_restart)
        else $error("Restart bit not cleared by hardware");

    a_expiry_flag: assert property (
        expire |=> expiry_irq_flag)
        else $error("Expiry did not set the flag");

    a_irq_gating: assert property (
        expiry_irq_flag && wdog_irq_enable && global_irq_enable
        |=> wdog_irq_req)
        else $error("Interrupt not requested");

    a_irq_masked: assert property (
        !wdog_irq_enable || !global_irq_enable |=> !wdog_irq_req)
        else $error("Masked interrupt requested");

    a_reset_delay: assert property (
        wdog_core_reset |-> since_expiry == 10'd512)
        else $error("Reset not 512 clocks after expiry");

    a_reset_gated: assert property (
        !reset_gen_enable |=> !wdog_core_reset)
        else $error("Reset while reset generation disabled");

    a_cause_kept: assert property (
        !reset_gen_enable && !wr_wdctl |=> $stable(reset_cause_flag))
        else $error("Cause flag changed while disabled");

    a_cause_set: assert property (
        wdog_core_reset |-> reset_cause_flag)
        else $error("Watchdog reset without cause flag");

    a_runs_after_rst: assert property (
        wdog_core_reset && !restart_now
        |-> (count == '0) ##1 (count == COUNT_W'(1)))
        else $error("Counter not running after reset");

    a_interval_write: assert property (
        sfr_wr && (sfr_addr == ADDR_CKCTL)
        |=> interval_select == $past(sfr_wdata[7:6]))
        else $error("Interval field not updated");
endmodule

// ---- verification/wdtac_watchdog_tb.sv ----
// Self-checking testbench for the watchdog with timed-access protection
`timescale 1ns/1ps
module wdtac_watchdog_tb;
    import wdtac_pkg::*;

    // ----------------------------------------------------------------
    // Stimulus and observation signals
    // ----------------------------------------------------------------
    localparam int IV [4] = '{640, 704, 768, 832};
    logic       clk;
    logic       rst;
    logic [7:0] sfr_addr;
    logic       sfr_wr;
    logic       sfr_rd;
    logic [7:0] sfr_wdata;
    logic       global_irq_enable;
    logic [7:0] sfr_rdata;
    logic       wdog_irq_req;
    logic       wdog_irq_high;
    logic       wdog_core_reset;
    logic [2:0] stretch_field;
    int         n_mismatch;
    int         samples_checked;
    int         n_pulse;
    int         n;
    int         p0;

    // Short intervals keep the run small, still wider than the 512 window
    wdtac_watchdog #(
        .INTERVAL_0 (IV[0]),
        .INTERVAL_1 (IV[1]),
        .INTERVAL_2 (IV[2]),
        .INTERVAL_3 (IV[3])
    ) wdtac_watchdog_i (
        .clk               (clk),
        .rst               (rst),
        .sfr_addr          (sfr_addr),
        .sfr_wr            (sfr_wr),
        .sfr_rd            (sfr_rd),
        .sfr_wdata         (sfr_wdata),
        .global_irq_enable (global_irq_enable),
        .sfr_rdata         (sfr_rdata),
        .wdog_irq_req      (wdog_irq_req),
        .wdog_irq_high     (wdog_irq_high),
        .wdog_core_reset   (wdog_core_reset),
        .stretch_field     (stretch_field)
    );

    initial clk = 1'b0;
    always #20 clk = ~clk;

    always @(negedge clk)
    begin
        if (wdog_core_reset === 1'b1)
            n_pulse++;
    end

    // ----------------------------------------------------------------
    // Access and compare tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask

    // Strobe held across exactly one rising edge, then an idle cycle
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        @(negedge clk);
        sfr_wr    = 1'b0;
    endtask

    task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd   = 1'b1;
        @(negedge clk);
        sfr_rd   = 1'b0;
        d        = sfr_rdata;
    endtask

    task automatic read_check(input logic [7:0] a, input logic [7:0] mask,
                              input logic [7:0] exp);
        logic [7:0] v;
        sfr_read(a, v);
        check("register read", exp, v & mask);
    endtask

    task automatic keyed_write(input logic [7:0] d);
        sfr_write(ADDR_TAKEY, UNLOCK_KEY_A);
        sfr_write(ADDR_TAKEY, UNLOCK_KEY_B);
        sfr_write(ADDR_WDCTL, d);
    endtask

    // Counts rising edges until the chosen output is seen high
    task automatic wait_out(input bit pick_reset, input int limit,
                            output int cnt);
        cnt = 0;
        do
        begin
            @(posedge clk);
            @(negedge clk);
            cnt++;
        end
        while (!((pick_reset ? wdog_core_reset : wdog_irq_req) === 1'b1)
               && cnt < limit);
    endtask

    task automatic final_report();
        $display("mismatches %0d, comparisons %0d", n_mismatch,
                 samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Watchdog on the run itself
    // ----------------------------------------------------------------
    initial
    begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        final_report();
    end

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial
    begin
        n_mismatch = 0;
        samples_checked = 0;
        n_pulse = 0;
        rst = 1'b1;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        global_irq_enable = 1'b1;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        check("stretch at reset", 3'b011, stretch_field);
        check("priority at reset", 1'b0, wdog_irq_high);
        read_check(ADDR_CKCTL, 8'hff, 8'h03);
        read_check(ADDR_WDCTL, 8'hff, 8'h00);
        read_check(ADDR_TAKEY, 8'hff, 8'h00);
        read_check(8'h10, 8'hff, 8'h00);
        // Locked, cancelled and consumed unlocks must all drop the write
        sfr_write(ADDR_WDCTL, 8'h02);
        read_check(ADDR_WDCTL, 8'h07, 8'h00);
        sfr_write(ADDR_TAKEY, UNLOCK_KEY_A);
        read_check(ADDR_CKCTL, 8'hff, 8'h03);
        sfr_write(ADDR_TAKEY, UNLOCK_KEY_B);
        sfr_write(ADDR_WDCTL, 8'h02);
        read_check(ADDR_WDCTL, 8'h07, 8'h00);
        sfr_write(ADDR_TAKEY, UNLOCK_KEY_A);
        sfr_write(ADDR_TAKEY, UNLOCK_KEY_B);
        sfr_write(ADDR_CKCTL, 8'h03);
        sfr_write(ADDR_WDCTL, 8'h02);
        read_check(ADDR_WDCTL, 8'h07, 8'h00);
        keyed_write(8'h04);
        read_check(ADDR_WDCTL, 8'h07, 8'h04);
        sfr_write(ADDR_WDCTL, 8'h00);
        read_check(ADDR_WDCTL, 8'h07, 8'h04);
        keyed_write(8'h01);
        read_check(ADDR_WDCTL, 8'h07, 8'h00);
        sfr_write(ADDR_CKCTL, 8'hc5);
        read_check(ADDR_CKCTL, 8'hff, 8'hc5);
        check("stretch field", 3'b101, stretch_field);
        sfr_write(ADDR_XIEN, 8'hff);
        read_check(ADDR_XIEN, 8'hff, 8'h10);
        sfr_write(ADDR_XIPR, 8'h10);
        read_check(ADDR_XIPR, 8'hff, 8'h10);
        check("priority output", 1'b1, wdog_irq_high);
        // Every interval select, measured from restart to request
        for (int s = 0; s < 4; s++)
        begin
            sfr_write(ADDR_CKCTL, {s[1:0], 6'h03});
            keyed_write(8'h01);
            wait_out(1'b0, 2000, n);
            check("interval cycles", IV[s] + 1, n);
        end
        read_check(ADDR_WDCTL, 8'h0f, 8'h08);
        global_irq_enable = 1'b0;
        repeat (3) @(negedge clk);
        check("request without global", 1'b0, wdog_irq_req);
        global_irq_enable = 1'b1;
        sfr_write(ADDR_XIEN, 8'h00);
        repeat (2) @(negedge clk);
        check("request when disabled", 1'b0, wdog_irq_req);
        sfr_write(ADDR_XIEN, 8'h10);
        keyed_write(8'h00);
        repeat (3) @(negedge clk);
        check("request after clear", 1'b0, wdog_irq_req);
        keyed_write(8'h08);
        repeat (2) @(negedge clk);
        check("software flag request", 1'b1, wdog_irq_req);
        // Delayed core reset, one pulse, cause flag, then free running
        sfr_write(ADDR_CKCTL, 8'h03);
        keyed_write(8'h03);
        p0 = n_pulse;
        wait_out(1'b1, 3000, n);
        check("reset delay", IV[0] + 512, n);
        repeat (2) @(negedge clk);
        check("single pulse", p0 + 1, n_pulse);
        read_check(ADDR_WDCTL, 8'h0f, 8'h0e);
        // Four cycles of this period went on the checks just above
        wait_out(1'b1, 3000, n);
        check("reset period", IV[0] + 508, n);
        // A restart inside the window cancels the pending reset
        keyed_write(8'h03);
        repeat (IV[0] + 100) @(negedge clk);
        keyed_write(8'h03);
        wait_out(1'b1, 3000, n);
        check("restart in window", IV[0] + 512, n);
        // Reset disabled: flag still set, cause never touched
        keyed_write(8'h01);
        p0 = n_pulse;
        repeat (IV[0] + 600) @(negedge clk);
        check("no reset when off", p0, n_pulse);
        read_check(ADDR_WDCTL, 8'h0f, 8'h08);
        // Cause flag set by software with reset generation armed
        keyed_write(8'h07);
        repeat (50) @(negedge clk);
        check("software cause flag", p0, n_pulse);
        read_check(ADDR_WDCTL, 8'h07, 8'h06);
        final_report();
    end
endmodule
